//--- hw/gcp_pkg.sv
// Package for the instrument bus controller port: timing, layouts, commands.
// Assumes a single 200 MHz clock feeding every file that uses it.
package gcp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int TMO_US = 100;
	localparam int TMO_CYC = TMO_US * CLK_MHZ;
	localparam int IFC_US = 100;
	localparam int IFC_CYC = IFC_US * CLK_MHZ;
	localparam int POLL_NS = 2000;
	localparam int POLL_CYC = (POLL_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_CYC = 3;
	localparam int TMR_W = 16;

	// ==========================================================
	// Field positions and values after reset
	localparam int ATN_BIT = 4;
	localparam logic [4:0] ADDR_RST = 5'h04;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam int DATA_W = 8;
	localparam int FIFO_W = 9;
	localparam int FIFO_DEPTH = 8;

	// ==========================================================
	// Commands, states and carriers
	typedef enum logic [3:0] {
		OP_IFC = 4'h0,
		OP_REN_ON = 4'h1,
		OP_REN_OFF = 4'h2,
		OP_STANDBY = 4'h3,
		OP_IMSG = 4'h4,
		OP_LISTEN = 4'h5,
		OP_TALK = 4'h6,
		OP_DMSG = 4'h7,
		OP_RECV = 4'h8,
		OP_POLL = 4'h9,
		OP_SET_ADDR = 4'ha
	} gcp_op_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_IFC = 7'h02,
		ST_SRC_WAIT = 7'h04,
		ST_SRC_DAV = 7'h08,
		ST_ACC_RDY = 7'h10,
		ST_ACC_TAKE = 7'h20,
		ST_POLL = 7'h40
	} gcp_state_t;

	typedef struct packed {
		gcp_op_t op;
		logic [7:0] data;
		logic last;
	} gcp_cmd_t;

	typedef struct packed {
		logic [7:0] dio;
		logic eoi;
		logic dav;
		logic nrfd;
		logic ndac;
		logic srq;
	} gcp_bus_in_t;

	typedef struct packed {
		logic [7:0] dio;
		logic eoi;
		logic dav;
		logic nrfd;
		logic ndac;
		logic atn;
		logic ifc;
		logic ren;
	} gcp_bus_out_t;

	typedef struct packed {
		logic ndp;
		logic rto;
		logic ato;
		logic refused;
	} gcp_err_t;

endpackage

//--- hw/gcp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module gcp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [CW-1:0] next_count;
	logic push;
	logic pop;

	// ==========================================================
	// Handshake and pointer update
	assign in_ready = count != FULL;
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push)
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		if (pop)
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	// Registers; storage has no reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else if (clk_en)
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
		if (clk_en && push)
			mem[wr_ptr] <= in_data;
	end

endmodule

//--- hw/gcp_port.sv
// Controller-side instrument bus port: handshakes, control lines, poll.
// Assumes open-drain bus drivers outside; bus inputs are asynchronous.
// What this block does
// - Data transceiver direction follows read/write strobe only when enabled and selected.
// - Data bits pass unchanged in both directions.
// - Port B write while idle with no command pending makes ATN follow CPU data bit 4.
// - Asserted SRQ raises the interrupt request.
// - NRFD, NDAC, DAV, EOI are two-way; drive set by port state.
// - Bytes move bit-parallel on eight lines, paced by DAV, NRFD, NDAC.
// - Each handshake step starts only after the previous completed.
// - Roles assigned by asserting ATN and sending talk/listen address.
// - Under ATN only seven bits used; otherwise up to eight.
// - ATN plus EOI together starts a parallel poll.
// - Up to 15 devices, 32 addresses; target address defaults to 4.
// - Port rests in source or acceptor handshake mode.
// - SRQ status and parallel poll only in source mode.
// - Exit modes: interface msg ATN true, device out/in ATN false.
// - Sending: address target as listener, then source bytes.
// - Receiving: address source as talker, then accept bytes.
// - Controller may address talker and listener, then stand by.
// - Interface clear initialises port and drives IFC for 100 us.
// - Standby only releases ATN and floats data lines.
// - NRFD held true over 100 us during source handshake reports timeout.
`timescale 1ns/1ps
module gcp_port #(
	parameter int TMO_CYCLES = gcp_pkg::TMO_CYC,
	parameter int IFC_CYCLES = gcp_pkg::IFC_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic cpu_enable,
	input wire logic cpu_port_select,
	input wire logic cpu_read_write_strobe,
	input wire logic cpu_port_b,
	input wire logic [7:0] cpu_wdata,
	output logic cpu_data_dir,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire gcp_pkg::gcp_cmd_t cmd,
	output logic busy,
	output gcp_pkg::gcp_err_t err,
	output logic err_any,
	output logic src_mode,
	output logic srq_status,
	output logic irq,
	output logic [7:0] poll_byte,
	output logic poll_valid,
	output logic [8:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire gcp_pkg::gcp_bus_in_t bus_in,
	output gcp_pkg::gcp_bus_out_t bus_out,
	output gcp_pkg::gcp_bus_out_t bus_oe
);
	localparam logic [15:0] TMO_LAST = 16'(TMO_CYCLES - 1);
	localparam logic [15:0] IFC_LAST = 16'(IFC_CYCLES - 1);
	localparam logic [15:0] POLL_LAST = 16'(gcp_pkg::POLL_CYC - 1);
	localparam logic [15:0] SYNC_MIN = 16'(gcp_pkg::SYNC_CYC);

	gcp_pkg::gcp_bus_in_t sync1;
	gcp_pkg::gcp_bus_in_t sync2;
	gcp_pkg::gcp_state_t st;
	gcp_pkg::gcp_state_t next_st;
	gcp_pkg::gcp_err_t next_err;
	logic next_src_mode, atn, next_atn, ifc, next_ifc, ren, next_ren;
	logic dav, next_dav, eoi, next_eoi, nrfd, next_nrfd, ndac, next_ndac;
	logic dio_en, next_dio_en, acc_last, next_acc_last;
	logic next_cpu_data_dir, next_poll_valid;
	logic [7:0] tx, next_tx, next_poll_byte;
	logic [4:0] target_addr, next_target_addr;
	logic [15:0] tmr, next_tmr;
	logic nrfd_true, ndac_true, dav_true, eoi_true, srq_true;
	logic fifo_in_valid, fifo_in_ready, port_b_write;

	// ==========================================================
	// Bus input synchroniser, two stages
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sync1 <= '1;
			sync2 <= '1;
		end
		else if (clk_en)
		begin
			sync1 <= bus_in;
			sync2 <= sync1;
		end
	end

	// Line low means true
	assign nrfd_true = !sync2.nrfd;
	assign ndac_true = !sync2.ndac;
	assign dav_true = !sync2.dav;
	assign eoi_true = !sync2.eoi;
	assign srq_true = !sync2.srq;

	// ==========================================================
	// Status and CPU-side outputs
	assign irq = srq_true;
	assign srq_status = src_mode && srq_true;
	assign busy = st != gcp_pkg::ST_IDLE;
	assign cmd_ready = st == gcp_pkg::ST_IDLE;
	assign err_any = |err;
	assign port_b_write = cpu_enable && cpu_port_select && !cpu_read_write_strobe && cpu_port_b;

	// ==========================================================
	// Bus drive: control lines pull low when enabled; data lines carry tx
	always_comb
	begin
		bus_out = '0;
		bus_out.dio = tx;
		bus_oe.dio = {8{dio_en}};
		bus_oe.eoi = eoi;
		bus_oe.dav = dav;
		bus_oe.nrfd = nrfd;
		bus_oe.ndac = ndac;
		bus_oe.atn = atn;
		bus_oe.ifc = ifc;
		bus_oe.ren = ren;
	end

	// ==========================================================
	// Received bytes with their end flag, stalled by a full buffer
	gcp_fifo #(
		.WIDTH(gcp_pkg::FIFO_W),
		.DEPTH(gcp_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({eoi_true, sync2.dio}),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// Push once the talker shows data while we are ready
	assign fifo_in_valid = (st == gcp_pkg::ST_ACC_RDY) && !nrfd && dav_true;

	// ==========================================================
	// Port sequencer: next values
	always_comb
	begin
		next_st = st;
		next_err = err;
		next_src_mode = src_mode;
		next_atn = atn;
		next_ifc = ifc;
		next_ren = ren;
		next_dav = dav;
		next_eoi = eoi;
		next_nrfd = nrfd;
		next_ndac = ndac;
		next_dio_en = dio_en;
		next_acc_last = acc_last;
		next_tx = tx;
		next_target_addr = target_addr;
		next_tmr = tmr + 1'b1;
		next_poll_byte = poll_byte;
		next_poll_valid = 1'b0;
		next_cpu_data_dir = cpu_data_dir;
		// Transceiver direction latched from the strobe only while enabled and selected
		if (cpu_enable && cpu_port_select)
			next_cpu_data_dir = cpu_read_write_strobe;
		case (st)
			gcp_pkg::ST_IDLE:
			begin
				next_tmr = '0;
				if (cmd_valid)
				begin
					case (cmd.op)
						gcp_pkg::OP_IFC:
						begin
							// Reset port to source standby, then pulse IFC
							next_err = '0;
							next_ifc = 1'b1;
							next_src_mode = 1'b1;
							next_atn = 1'b0;
							next_dav = 1'b0;
							next_eoi = 1'b0;
							next_nrfd = 1'b0;
							next_ndac = 1'b0;
							next_dio_en = 1'b0;
							next_st = gcp_pkg::ST_IFC;
						end
						gcp_pkg::OP_REN_ON: next_ren = 1'b1;
						gcp_pkg::OP_REN_OFF: next_ren = 1'b0;
						gcp_pkg::OP_SET_ADDR: next_target_addr = cmd.data[4:0];
						gcp_pkg::OP_STANDBY:
						begin
							// Release ATN and float data only
							if (src_mode)
							begin
								next_atn = 1'b0;
								next_dio_en = 1'b0;
							end
							else
								next_err.refused = 1'b1;
						end
						gcp_pkg::OP_IMSG, gcp_pkg::OP_LISTEN, gcp_pkg::OP_TALK,
						gcp_pkg::OP_DMSG:
						begin
							// Enter source mode and place the byte
							next_err = '0;
							next_src_mode = 1'b1;
							next_nrfd = 1'b0;
							next_ndac = 1'b0;
							next_dio_en = 1'b1;
							next_atn = cmd.op != gcp_pkg::OP_DMSG;
							next_eoi = (cmd.op == gcp_pkg::OP_DMSG) && cmd.last;
							// Interface messages keep bit 7 clear
							next_tx = {1'b0, cmd.data[6:0]};
							if (cmd.op == gcp_pkg::OP_LISTEN)
								next_tx = gcp_pkg::LISTEN_BASE | {3'h0, target_addr};
							else if (cmd.op == gcp_pkg::OP_TALK)
								next_tx = gcp_pkg::TALK_BASE | {3'h0, target_addr};
							else if (cmd.op == gcp_pkg::OP_DMSG)
								next_tx = cmd.data;
							next_st = gcp_pkg::ST_SRC_WAIT;
						end
						gcp_pkg::OP_RECV:
						begin
							// Acceptor mode, ATN false, hold off talker
							next_err = '0;
							next_src_mode = 1'b0;
							next_atn = 1'b0;
							next_dio_en = 1'b0;
							next_dav = 1'b0;
							next_eoi = 1'b0;
							next_nrfd = 1'b1;
							next_ndac = 1'b1;
							next_st = gcp_pkg::ST_ACC_RDY;
						end
						gcp_pkg::OP_POLL:
						begin
							// ATN with EOI, source mode only
							if (src_mode)
							begin
								next_atn = 1'b1;
								next_eoi = 1'b1;
								next_dio_en = 1'b0;
								next_st = gcp_pkg::ST_POLL;
							end
							else
								next_err.refused = 1'b1;
						end
						default: next_err.refused = 1'b1;
					endcase
				end
				else if (port_b_write)
					next_atn = cpu_wdata[gcp_pkg::ATN_BIT];
			end
			gcp_pkg::ST_IFC:
			begin
				if (tmr == IFC_LAST)
				begin
					next_ifc = 1'b0;
					next_st = gcp_pkg::ST_IDLE;
				end
			end
			gcp_pkg::ST_SRC_WAIT:
			begin
				// Wait out synchroniser lag before trusting NRFD
				if (tmr >= SYNC_MIN && !nrfd_true && !ndac_true)
				begin
					next_err.ndp = 1'b1;
					next_eoi = 1'b0;
					next_st = gcp_pkg::ST_IDLE;
				end
				else if (tmr >= SYNC_MIN && !nrfd_true)
				begin
					next_dav = 1'b1;
					next_tmr = '0;
					next_st = gcp_pkg::ST_SRC_DAV;
				end
				else if (tmr == TMO_LAST)
				begin
					next_err.rto = 1'b1;
					next_eoi = 1'b0;
					next_st = gcp_pkg::ST_IDLE;
				end
			end
			gcp_pkg::ST_SRC_DAV:
			begin
				// Release DAV once all listeners accept
				if (tmr >= SYNC_MIN && !ndac_true)
				begin
					next_dav = 1'b0;
					next_eoi = 1'b0;
					next_st = gcp_pkg::ST_IDLE;
				end
				else if (tmr == TMO_LAST)
				begin
					next_err.ato = 1'b1;
					next_dav = 1'b0;
					next_eoi = 1'b0;
					next_st = gcp_pkg::ST_IDLE;
				end
			end
			gcp_pkg::ST_ACC_RDY:
			begin
				// Ready only while the buffer has room
				next_nrfd = !fifo_in_ready;
				if (fifo_in_valid && fifo_in_ready)
				begin
					next_acc_last = eoi_true;
					next_nrfd = 1'b1;
					next_ndac = 1'b0;
					next_st = gcp_pkg::ST_ACC_TAKE;
				end
			end
			gcp_pkg::ST_ACC_TAKE:
			begin
				// Re-arm only after the talker drops DAV
				if (!dav_true)
				begin
					next_ndac = 1'b1;
					next_st = acc_last ? gcp_pkg::ST_IDLE : gcp_pkg::ST_ACC_RDY;
				end
			end
			gcp_pkg::ST_POLL:
			begin
				if (tmr == POLL_LAST)
				begin
					next_poll_byte = sync2.dio;
					next_poll_valid = 1'b1;
					next_eoi = 1'b0;
					next_st = gcp_pkg::ST_IDLE;
				end
			end
			default: next_st = gcp_pkg::ST_IDLE;
		endcase
	end

	// Port sequencer: registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			st <= gcp_pkg::ST_IDLE;
			err <= '0;
			src_mode <= 1'b1;
			atn <= 1'b0;
			ifc <= 1'b0;
			ren <= 1'b0;
			dav <= 1'b0;
			eoi <= 1'b0;
			nrfd <= 1'b0;
			ndac <= 1'b0;
			dio_en <= 1'b0;
			acc_last <= 1'b0;
			tx <= '0;
			target_addr <= gcp_pkg::ADDR_RST;
			tmr <= '0;
			poll_byte <= '0;
			poll_valid <= 1'b0;
			cpu_data_dir <= 1'b0;
		end
		else if (clk_en)
		begin
			st <= next_st;
			err <= next_err;
			src_mode <= next_src_mode;
			atn <= next_atn;
			ifc <= next_ifc;
			ren <= next_ren;
			dav <= next_dav;
			eoi <= next_eoi;
			nrfd <= next_nrfd;
			ndac <= next_ndac;
			dio_en <= next_dio_en;
			acc_last <= next_acc_last;
			tx <= next_tx;
			target_addr <= next_target_addr;
			tmr <= next_tmr;
			poll_byte <= next_poll_byte;
			poll_valid <= next_poll_valid;
			cpu_data_dir <= next_cpu_data_dir;
		end
	end

	// ==========================================================
	// Assertions and covers
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_dir_hold: assert property (clk_en && !(cpu_enable && cpu_port_select) |=> $stable(cpu_data_dir))
		else $error("direction moved without strobe");
	a_dir_follow: assert property (clk_en && cpu_enable && cpu_port_select |=> cpu_data_dir == $past(cpu_read_write_strobe))
		else $error("direction not from strobe");
	a_atn_port_b: assert property (clk_en && !busy && !cmd_valid && port_b_write |=> bus_oe.atn == $past(cpu_wdata[4]))
		else $error("ATN not from data bit 4");
	a_irq_srq: assert property (clk_en && !bus_in.srq ##1 clk_en && !bus_in.srq |=> irq)
		else $error("SRQ did not raise irq");
	a_mode_lines: assert property (src_mode |-> !bus_oe.nrfd && !bus_oe.ndac)
		else $error("acceptor lines driven in source mode");
	a_acc_lines: assert property (!src_mode |-> bus_oe.dio == 8'h00 && !bus_oe.dav && !bus_oe.atn)
		else $error("source lines driven in acceptor mode");
	a_atn_7bit: assert property (bus_oe.atn && bus_oe.dav |-> !bus_out.dio[7])
		else $error("bit 7 set under ATN");
	a_dav_gate: assert property ($rose(bus_oe.dav) |-> $past(!nrfd_true))
		else $error("DAV before listeners ready");
	a_poll_lines: assert property (st == gcp_pkg::ST_POLL |-> bus_oe.atn && bus_oe.eoi && src_mode)
		else $error("poll without ATN and EOI");
	a_ifc_start: assert property ($rose(bus_oe.ifc) |-> bus_oe.ifc [*8] ##0 !bus_oe.atn)
		else $error("IFC pulse short or ATN left");
	a_standby: assert property (clk_en && !busy && cmd_valid && cmd.op == gcp_pkg::OP_STANDBY && src_mode
		|=> !bus_oe.atn && bus_oe.dio == 8'h00 && $stable(bus_oe.ren))
		else $error("standby changed other state");
	a_rto_cause: assert property ($rose(err.rto) |-> $past(st == gcp_pkg::ST_SRC_WAIT && nrfd_true))
		else $error("timeout without NRFD held");

	c_poll: cover property (poll_valid);
	c_rto: cover property ($rose(err.rto));
	c_rx_push: cover property (fifo_in_valid && fifo_in_ready && eoi_true);
	c_full_stall: cover property (st == gcp_pkg::ST_ACC_RDY && !fifo_in_ready);

endmodule

//--- test/gcp_bus_model.sv
// Behavioural instrument on the far side of the controller port.
// Assumes the bench resolves the wire levels; a released line reads high.
`timescale 1ns/1ps
module gcp_bus_model (
	input wire logic ref_clk,
	input wire logic present,
	input wire logic hold_nrfd,
	input wire logic [2:0] slow,
	input wire logic srq_req,
	input wire logic [7:0] poll_stat,
	input wire gcp_pkg::gcp_bus_in_t line,
	input wire logic atn_line,
	input wire logic ifc_line,
	output logic [7:0] m_dio,
	output logic m_eoi,
	output logic m_dav,
	output logic m_nrfd,
	output logic m_ndac,
	output logic m_srq,
	output logic got,
	output logic [8:0] got_data,
	output int sent_cnt
);
	logic [8:0] talk_q[$];

	// ==========================================================
	// Service request pulls its line low
	assign m_srq = ~srq_req;

	// One clock step; lines move just after the edge, never on it
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask

	// ==========================================================
	// Talker or listener, one handshake step after the other
	initial
	begin
		{m_dio, m_eoi, m_dav, m_nrfd, m_ndac, got} = {8'hff, 4'hf, 1'b0};
		got_data = 9'h000;
		sent_cnt = 0;
		forever
		begin
			step();
			if (!ifc_line)
				talk_q.delete();
			// Only a device given bytes to say acts as talker
			if (talk_q.size() > 0)
			begin
				{m_nrfd, m_ndac} = 2'h3;
				while (!line.nrfd) step();
				m_dio = talk_q[0][7:0];
				m_eoi = ~talk_q[0][8];
				repeat (2) step();
				m_dav = 1'b0;
				while (!line.ndac) step();
				{m_dio, m_eoi, m_dav} = {8'hff, 2'h3};
				void'(talk_q.pop_front());
				sent_cnt++;
			end
			else if (!present)
				{m_nrfd, m_ndac} = 2'h3;
			else
			begin
				m_dio = (!atn_line && !line.eoi) ? poll_stat : 8'hff;
				m_ndac = 1'b0;
				m_nrfd = ~hold_nrfd;
				if (!line.dav)
				begin
					repeat (slow) step();
					got_data = {~line.eoi, line.dio};
					got = 1'b1;
					{m_nrfd, m_ndac} = 2'h1;
					step();
					got = 1'b0;
					while (!line.dav) step();
					m_ndac = 1'b0;
					repeat (slow) step();
				end
			end
		end
	end
endmodule

//--- test/test_gcp_port.sv
// Self-checking bench for the controller port against an instrument model.
// Assumes the package and design compile first; short timeout parameters.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_gcp_port;
	localparam int TMO = 16;
	localparam int IFC = 16;
	logic ref_clk, sys_rst, cpu_enable, cpu_port_select, cpu_read_write_strobe, cpu_port_b;
	logic cmd_valid, cmd_ready, busy, err_any, src_mode, srq_status, irq, poll_valid;
	logic cpu_data_dir, rx_valid, rx_ready, present, hold_nrfd, srq_req, got, atn_line, ifc_line;
	logic m_eoi, m_dav, m_nrfd, m_ndac, m_srq;
	logic [2:0] slow;
	logic [7:0] cpu_wdata, poll_byte, poll_stat, m_dio, lfsr;
	logic [8:0] rx_data, got_data, exp_val;
	logic [8:0] exp_q[$];
	gcp_pkg::gcp_cmd_t cmd;
	gcp_pkg::gcp_err_t err;
	gcp_pkg::gcp_bus_in_t line;
	gcp_pkg::gcp_bus_out_t bus_out, bus_oe;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	int ifc_n, sent_cnt;

	gcp_port #(.TMO_CYCLES(TMO), .IFC_CYCLES(IFC)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .cpu_enable(cpu_enable), .cpu_port_select(cpu_port_select),
		.cpu_read_write_strobe(cpu_read_write_strobe), .cpu_port_b(cpu_port_b),
		.cpu_wdata(cpu_wdata), .cpu_data_dir(cpu_data_dir), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .busy(busy), .err(err), .err_any(err_any),
		.src_mode(src_mode), .srq_status(srq_status), .irq(irq), .poll_byte(poll_byte),
		.poll_valid(poll_valid), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.bus_in(line), .bus_out(bus_out), .bus_oe(bus_oe));

	gcp_bus_model bm (.ref_clk(ref_clk), .present(present), .hold_nrfd(hold_nrfd),
		.slow(slow), .srq_req(srq_req), .poll_stat(poll_stat), .line(line),
		.atn_line(atn_line), .ifc_line(ifc_line), .m_dio(m_dio), .m_eoi(m_eoi), .m_dav(m_dav),
		.m_nrfd(m_nrfd), .m_ndac(m_ndac), .m_srq(m_srq), .got(got), .got_data(got_data),
		.sent_cnt(sent_cnt));

	// ==========================================================
	// Wire levels: a driver pulls low, a released line is pulled up
	function automatic logic lv(logic oe, logic o, logic m);
		return (oe ? o : 1'b1) & m;
	endfunction

	always_comb
	begin
		line.dio = (bus_oe.dio[0] ? bus_out.dio : 8'hff) & m_dio;
		line.eoi = lv(bus_oe.eoi, bus_out.eoi, m_eoi);
		line.dav = lv(bus_oe.dav, bus_out.dav, m_dav);
		line.nrfd = lv(bus_oe.nrfd, bus_out.nrfd, m_nrfd);
		line.ndac = lv(bus_oe.ndac, bus_out.ndac, m_ndac);
		line.srq = m_srq;
	end
	assign atn_line = lv(bus_oe.atn, bus_out.atn, 1'b1);
	assign ifc_line = lv(bus_oe.ifc, bus_out.ifc, 1'b1);

	// ==========================================================
	// Clock, hang limit and scoreboard
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			final_report();
		end
	end

	// Oldest note is compared against each result that appears
	always @(negedge ref_clk)
	begin
		if (got || poll_valid || (rx_valid && rx_ready))
		begin
			exp_val = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
			if (got) `CHK(got_data, exp_val)
			else if (poll_valid) `CHK({1'b0, poll_byte}, exp_val)
			else `CHK(rx_data, exp_val)
		end
	end

	// ==========================================================
	// Stimulus helpers
	function automatic logic [7:0] lfsr_next(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic cpu_acc(logic en, logic sel, logic rw, logic pb, logic [7:0] wd);
		{cpu_enable, cpu_port_select, cpu_read_write_strobe, cpu_port_b} = {en, sel, rw, pb};
		cpu_wdata = wd;
		tk(1);
		{cpu_enable, cpu_port_select} = 2'h0;
		tk(1);
	endtask

	// Holds the request until taken, then waits for busy to fall
	task automatic run(gcp_pkg::gcp_op_t op, logic [7:0] d, logic l);
		int n;
		n = 0;
		cmd = '{op: op, data: d, last: l};
		cmd_valid = 1'b1;
		while (!cmd_ready && n < 30000)
		begin
			n++;
			tk(1);
		end
		tk(1);
		cmd_valid = 1'b0;
		ifc_n = 0;
		do
		begin
			ifc_n += bus_oe.ifc;
			tk(1);
			n++;
		end
		while (busy && n < 30000);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{sys_rst, cmd_valid, rx_ready, srq_req, hold_nrfd} = 5'h14;
		{cpu_enable, cpu_port_select, cpu_read_write_strobe, cpu_port_b} = 4'h0;
		{cpu_wdata, poll_stat, slow, present, lfsr} = {8'h00, 8'h00, 3'h0, 1'b1, 8'h18};
		cmd = '0;
		tk(6);
		sys_rst = 1'b0;
		`CHK({src_mode, cmd_ready, bus_oe}, {2'h3, 15'h0000})
		// Transceiver direction and port B attention drive
		cpu_acc(1, 1, 1, 0, 8'h00);
		`CHK(cpu_data_dir, 1'b1)
		cpu_acc(1, 0, 0, 0, 8'h00);
		`CHK(cpu_data_dir, 1'b1)
		cpu_acc(0, 1, 0, 0, 8'h00);
		`CHK(cpu_data_dir, 1'b1)
		for (int i = 0; i < 2; i++)
		begin
			lfsr = lfsr_next(lfsr);
			cpu_acc(1, 1, 0, 1, {lfsr[7:5], ~i[0], lfsr[3:0]});
			`CHK({bus_oe.atn, cpu_data_dir}, {~i[0], 1'b0})
		end
		// Remote enable survives interface clear
		run(gcp_pkg::OP_REN_ON, 8'h00, 1'b0);
		`CHK(bus_oe.ren, 1'b1)
		run(gcp_pkg::OP_IFC, 8'h00, 1'b0);
		`CHK(ifc_n, IFC)
		`CHK({bus_oe.ren, bus_oe.atn, src_mode}, 3'h5)
		// Address default target as listener, then send random bytes
		exp_q.push_back(9'h024);
		run(gcp_pkg::OP_LISTEN, 8'h00, 1'b0);
		`CHK(bus_oe.atn, 1'b1)
		for (int i = 0; i < 4; i++)
		begin
			lfsr = lfsr_next(lfsr);
			slow = lfsr[2:0];
			exp_q.push_back({i == 3, lfsr});
			run(gcp_pkg::OP_DMSG, lfsr, i == 3);
		end
		`CHK({bus_oe.atn, src_mode, err_any}, 3'h2)
		run(gcp_pkg::OP_SET_ADDR, 8'h07, 1'b0);
		exp_q.push_back(9'h047);
		run(gcp_pkg::OP_TALK, 8'h00, 1'b0);
		exp_q.push_back(9'h03f);
		run(gcp_pkg::OP_IMSG, 8'hbf, 1'b0);
		`CHK(bus_oe.atn, 1'b1)
		run(gcp_pkg::OP_STANDBY, 8'h00, 1'b0);
		`CHK({bus_oe.atn, bus_oe.dio, bus_oe.ren}, 10'h001)
		// Service request and parallel poll in source mode
		srq_req = 1'b1;
		tk(4);
		`CHK({irq, srq_status}, 2'h3)
		srq_req = 1'b0;
		lfsr = lfsr_next(lfsr);
		poll_stat = lfsr;
		exp_q.push_back({1'b0, lfsr});
		run(gcp_pkg::OP_POLL, 8'h00, 1'b0);
		`CHK(bus_oe.atn, 1'b1)
		// Not-ready timeout, then nobody present
		hold_nrfd = 1'b1;
		run(gcp_pkg::OP_DMSG, 8'h55, 1'b1);
		`CHK({err.rto, bus_oe.dav, bus_oe.eoi, err_any}, 4'h9)
		{hold_nrfd, present} = 2'h0;
		run(gcp_pkg::OP_DMSG, 8'h55, 1'b0);
		`CHK({err.ndp, err.rto}, 2'h2)
		present = 1'b1;
		// Receive nine bytes while the drain stalls: buffer refuses the ninth
		rx_ready = 1'b0;
		fork
			run(gcp_pkg::OP_RECV, 8'h00, 1'b0);
		join_none
		tk(4);
		for (int i = 0; i < 9; i++)
		begin
			lfsr = lfsr_next(lfsr);
			bm.talk_q.push_back({i == 8, lfsr});
			exp_q.push_back({i == 8, lfsr});
		end
		tk(200);
		`CHK(sent_cnt, 8)
		srq_req = 1'b1;
		tk(4);
		`CHK({src_mode, srq_status, irq}, 3'h1)
		srq_req = 1'b0;
		rx_ready = 1'b1;
		wait fork;
		tk(12);
		`CHK({sent_cnt[3:0], src_mode, bus_oe.atn, rx_valid}, 7'h48)
		// Acceptor mode refuses standby and poll
		run(gcp_pkg::OP_STANDBY, 8'h00, 1'b0);
		`CHK(err.refused, 1'b1)
		run(gcp_pkg::OP_POLL, 8'h00, 1'b0);
		`CHK({bus_oe.atn, bus_oe.eoi, src_mode}, 3'h0)
		run(gcp_pkg::OP_IFC, 8'h00, 1'b0);
		`CHK({src_mode, err_any}, 2'h2)
		run(gcp_pkg::OP_REN_OFF, 8'h00, 1'b0);
		`CHK({bus_oe.ren, exp_q.size() == 0}, 2'h1)
		final_report();
	end
endmodule
